/* File: adc_chan_flags.sv */
// Purpose: end-of-conversion and overrun flags of one channel
// Assumes: set and clear strobes are one-cycle, ce gates all state
// Notes: a set in the cycle of a clear wins
`timescale 1ns/1ns
`default_nettype none

module adc_chan_flags (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic set_eoc,
	input wire logic clr_eoc,
	input wire logic clr_channel_overrun_flag,
	output logic eoc_q,
	output logic channel_overrun_flag_q,
	output logic channel_overrun_flag_evt
);

	// new result while the old one is still unread
	assign channel_overrun_flag_evt = set_eoc & eoc_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eoc_q <= 1'b0;
		end else if (ce) begin
			eoc_q <= set_eoc | (eoc_q & ~clr_eoc);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_overrun_flag_q <= 1'b0;
		end else if (ce) begin
			channel_overrun_flag_q <= channel_overrun_flag_evt | (channel_overrun_flag_q & ~clr_channel_overrun_flag);
		end
	end

endmodule : adc_chan_flags

`default_nettype wire

/* File: adc_flag_map.svh */
// Purpose: constants for the converter status-flag block
// Assumes: 32-bit register bus, byte addresses, eight channels
// Notes: definitions only
`ifndef ADC_FLAG_MAP_SVH
`define ADC_FLAG_MAP_SVH

`define ADC_NUM_CH 8
`define ADC_CH_IDX_W 3
`define ADC_DATA_W 10
`define ADC_ADDR_W 8

// register byte offsets
`define ADC_OFS_CH_ENABLE 8'h00
`define ADC_OFS_CH_DISABLE 8'h04
`define ADC_OFS_CH_STATUS 8'h08
`define ADC_OFS_FLAG_STATUS 8'h0c
`define ADC_OFS_LAST_RESULT 8'h10
`define ADC_OFS_IRQ_STATUS 8'h14
`define ADC_OFS_IRQ_MASK 8'h18
`define ADC_OFS_RESULT_BASE 8'h20
`define ADC_OFS_RESULT_LAST 8'h3c

// flag status fields
`define ADC_FLD_EOC_LSB 0
`define ADC_FLD_CHANNEL_OVERRUN_FLAG_LSB 8
`define ADC_FLD_DATA_READY_FLAG_BIT 16
`define ADC_FLD_GENERAL_OVERRUN_FLAG_BIT 17
// last result fields
`define ADC_FLD_LAST_CH_LSB 12

// interrupt status and mask fields
`define ADC_IRQ_W 4
`define ADC_IRQ_STORED 0
`define ADC_IRQ_CHANNEL_OVERRUN_FLAG 1
`define ADC_IRQ_GENERAL_OVERRUN_FLAG 2
`define ADC_IRQ_DROPPED 3

`define ADC_RESP_OKAY 2'b00
`define ADC_RESP_SLVERR 2'b10
`define ADC_RESET_WORD 32'h0000_0000

`endif

/* File: adc_flag_pkg.sv */
// Purpose: shared types of the converter status-flag block
// Assumes: constants come from adc_flag_map.svh
// Notes: types only
`include "adc_flag_map.svh"

package adc_flag_pkg;

	typedef logic [`ADC_NUM_CH-1:0] chmask_t;
	typedef logic [`ADC_CH_IDX_W-1:0] chan_t;
	typedef logic [`ADC_DATA_W-1:0] sample_t;

	// end of conversion from the conversion core
	typedef struct packed {
		logic done;
		chan_t chan;
		sample_t data;
	} conv_evt_s;

	// a stored result and its origin
	typedef struct packed {
		chan_t chan;
		sample_t data;
	} result_s;

endpackage : adc_flag_pkg

/* File: adc_status_flags.sv */
// Purpose: status flags, result registers and bus slave of the converter controller
// Assumes: AXI4-Lite master, conversion core gives one-cycle end-of-conversion events
// Notes: reads of status and result registers have side effects at the read handshake
//
// Operation
// - Data-ready is cleared only by reading the last result register, never by a channel read.
// - An end of conversion on an enabled channel stores and sets data-ready despite other disables.
// - Data-ready is set only when new data is stored, and kept until the last result register is read.
// - A channel read during another enabled channel's end with its flag set still sets data-ready.
// - A status read during an end of conversion clears old general overrun; a store while data-ready is active sets a new one.
// - An end of conversion on an enabled channel while data-ready is active sets general overrun.
// - A channel read with an end on a channel holding both flags sets general overrun.
// - A disable of another channel colliding with an end on a channel holding both flags raises general overrun.
// - In that collision the ending channel's overrun flag is raised too.
// - A status read clears every channel overrun flag except one raised by a new end of conversion in that cycle.
// - A channel's end flag clears on a read of its result, or of the last result register while that holds its result.
// - A channel disabled while converting never raises its end flag.
// - A channel read during another channel's end clears only the read channel's end flag.
`timescale 1ns/1ns
`default_nettype none
`include "adc_flag_map.svh"

module adc_status_flags
	import adc_flag_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`ADC_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`ADC_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire conv_evt_s conv,
	output logic [`ADC_NUM_CH-1:0] chan_enable,
	output logic irq
);

	// ************************************************
	// address decoding
	// ************************************************

	function automatic logic result_hit(input logic [`ADC_ADDR_W-1:0] a);
		result_hit = (a >= `ADC_OFS_RESULT_BASE) && (a <= `ADC_OFS_RESULT_LAST) && (a[1:0] == 2'b00);
	endfunction : result_hit

	function automatic chan_t result_idx(input logic [`ADC_ADDR_W-1:0] a);
		logic [`ADC_ADDR_W-1:0] off;
		off = a - `ADC_OFS_RESULT_BASE;
		result_idx = off[`ADC_CH_IDX_W+1:2];
	endfunction : result_idx

	function automatic logic mapped(input logic [`ADC_ADDR_W-1:0] a);
		unique case (a)
			`ADC_OFS_CH_ENABLE, `ADC_OFS_CH_DISABLE, `ADC_OFS_CH_STATUS,
			`ADC_OFS_FLAG_STATUS, `ADC_OFS_LAST_RESULT,
			`ADC_OFS_IRQ_STATUS, `ADC_OFS_IRQ_MASK: mapped = 1'b1;
			default: mapped = result_hit(a);
		endcase
	endfunction : mapped

	// ************************************************
	// write channel
	// ************************************************

	logic aw_full_q;
	logic w_full_q;
	logic [`ADC_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_low_q;
	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic aw_full_d;
	logic w_full_d;
	logic bvalid_d;

	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	// address and data may arrive in either order; the write runs once both are held and no write answer is pending
	assign wr_fire = aw_full_q & w_full_q & ~bvalid;
	assign bvalid_d = wr_fire | (bvalid & ~bready);
	assign aw_full_d = (aw_full_q & ~wr_fire) | aw_take;
	assign w_full_d = (w_full_q & ~wr_fire) | w_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `ADC_RESP_OKAY;
		end else if (ce) begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready <= ~aw_full_d;
			wready <= ~w_full_d;
			bvalid <= bvalid_d;
			if (wr_fire) begin
				bresp <= mapped(aw_addr_q) ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q <= '0;
			w_data_q <= `ADC_RESET_WORD;
			w_low_q <= 1'b0;
		end else if (ce) begin
			if (aw_take) begin
				aw_addr_q <= awaddr;
			end
			if (w_take) begin
				w_data_q <= wdata;
				w_low_q <= wstrb[0];
			end
		end
	end

	// only the low byte lane carries control bits
	logic wr_en_ch;
	logic wr_dis_ch;
	logic wr_irq_stat;
	logic wr_irq_mask;

	assign wr_en_ch = wr_fire & w_low_q & (aw_addr_q == `ADC_OFS_CH_ENABLE);
	assign wr_dis_ch = wr_fire & w_low_q & (aw_addr_q == `ADC_OFS_CH_DISABLE);
	assign wr_irq_stat = wr_fire & w_low_q & (aw_addr_q == `ADC_OFS_IRQ_STATUS);
	assign wr_irq_mask = wr_fire & w_low_q & (aw_addr_q == `ADC_OFS_IRQ_MASK);

	// ************************************************
	// read channel strobes
	// ************************************************

	logic ar_take;
	logic rd_status;
	logic rd_last;
	chmask_t rd_result;

	assign ar_take = arvalid & arready;
	assign rd_status = ar_take & (araddr == `ADC_OFS_FLAG_STATUS);
	assign rd_last = ar_take & (araddr == `ADC_OFS_LAST_RESULT);

	generate
		for (genvar i = 0; i < `ADC_NUM_CH; i++) begin : g_rd
			assign rd_result[i] = ar_take & result_hit(araddr) & (result_idx(araddr) == chan_t'(i));
		end
	endgenerate

	// ************************************************
	// channel enables and conversion events
	// ************************************************

	chmask_t en_eff;
	logic store;
	logic dropped;
	chmask_t dis_mask;

	// a disable written in the very cycle of an end takes effect on that end
	assign dis_mask = wr_dis_ch ? w_data_q[`ADC_NUM_CH-1:0] : '0;
	assign en_eff = chan_enable & ~dis_mask;
	assign store = conv.done & en_eff[conv.chan];
	assign dropped = conv.done & ~en_eff[conv.chan];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_enable <= '0;
		end else if (ce) begin
			chan_enable <= (chan_enable | (wr_en_ch ? w_data_q[`ADC_NUM_CH-1:0] : '0)) & ~dis_mask;
		end
	end

	// ************************************************
	// result storage
	// ************************************************

	sample_t result_q [`ADC_NUM_CH];
	result_s last_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `ADC_NUM_CH; i++) begin
				result_q[i] <= '0;
			end
		end else if (ce && store) begin
			result_q[conv.chan] <= conv.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_q <= '0;
		end else if (ce && store) begin
			last_q <= '{chan: conv.chan, data: conv.data};
		end
	end

	// ************************************************
	// per-channel flags
	// ************************************************

	chmask_t eoc;
	chmask_t channel_overrun_flag;
	chmask_t channel_overrun_flag_evt;

	generate
		for (genvar i = 0; i < `ADC_NUM_CH; i++) begin : g_ch
			logic set_eoc;
			logic clr_eoc;
			assign set_eoc = store & (conv.chan == chan_t'(i));
			// a channel read clears only its own flag
			assign clr_eoc = rd_result[i] | (rd_last & (last_q.chan == chan_t'(i)));
			adc_chan_flags u_flags (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.set_eoc(set_eoc),
				.clr_eoc(clr_eoc),
				.clr_channel_overrun_flag(rd_status),
				.eoc_q(eoc[i]),
				.channel_overrun_flag_q(channel_overrun_flag[i]),
				.channel_overrun_flag_evt(channel_overrun_flag_evt[i])
			);
		end
	endgenerate

	// ************************************************
	// global flags
	// ************************************************

	logic data_ready_flag_q;
	logic general_overrun_flag_q;
	logic general_overrun_flag_evt;

	// any stored result landing on unread data is a general overrun,
	// whatever else is read or disabled in the same cycle
	assign general_overrun_flag_evt = store & data_ready_flag_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_ready_flag_q <= 1'b0;
		end else if (ce) begin
			// channel reads play no part here
			data_ready_flag_q <= store | (data_ready_flag_q & ~rd_last);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			general_overrun_flag_q <= 1'b0;
		end else if (ce) begin
			general_overrun_flag_q <= general_overrun_flag_evt | (general_overrun_flag_q & ~rd_status);
		end
	end

	// ************************************************
	// interrupts
	// ************************************************

	logic [`ADC_IRQ_W-1:0] irq_stat_q;
	logic [`ADC_IRQ_W-1:0] irq_mask_q;
	logic [`ADC_IRQ_W-1:0] irq_set;
	logic [`ADC_IRQ_W-1:0] irq_stat_d;
	logic [`ADC_IRQ_W-1:0] irq_mask_d;

	always_comb begin
		irq_set = '0;
		irq_set[`ADC_IRQ_STORED] = store;
		irq_set[`ADC_IRQ_CHANNEL_OVERRUN_FLAG] = |channel_overrun_flag_evt;
		irq_set[`ADC_IRQ_GENERAL_OVERRUN_FLAG] = general_overrun_flag_evt;
		irq_set[`ADC_IRQ_DROPPED] = dropped;
	end

	// set beats a write-one-to-clear in the same cycle
	assign irq_stat_d = irq_set | (irq_stat_q & ~(wr_irq_stat ? w_data_q[`ADC_IRQ_W-1:0] : '0));
	assign irq_mask_d = wr_irq_mask ? w_data_q[`ADC_IRQ_W-1:0] : irq_mask_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq <= |(irq_stat_d & irq_mask_d);
		end
	end

	// ************************************************
	// read data
	// ************************************************

	logic [31:0] rd_word;

	always_comb begin
		rd_word = `ADC_RESET_WORD;
		if (result_hit(araddr)) begin
			rd_word[`ADC_DATA_W-1:0] = result_q[result_idx(araddr)];
		end else begin
			unique case (araddr)
				`ADC_OFS_CH_STATUS: rd_word[`ADC_NUM_CH-1:0] = chan_enable;
				`ADC_OFS_FLAG_STATUS: begin
					rd_word[`ADC_FLD_EOC_LSB +: `ADC_NUM_CH] = eoc;
					rd_word[`ADC_FLD_CHANNEL_OVERRUN_FLAG_LSB +: `ADC_NUM_CH] = channel_overrun_flag;
					rd_word[`ADC_FLD_DATA_READY_FLAG_BIT] = data_ready_flag_q;
					rd_word[`ADC_FLD_GENERAL_OVERRUN_FLAG_BIT] = general_overrun_flag_q;
				end
				`ADC_OFS_LAST_RESULT: begin
					rd_word[`ADC_DATA_W-1:0] = last_q.data;
					rd_word[`ADC_FLD_LAST_CH_LSB +: `ADC_CH_IDX_W] = last_q.chan;
				end
				`ADC_OFS_IRQ_STATUS: rd_word[`ADC_IRQ_W-1:0] = irq_stat_q;
				`ADC_OFS_IRQ_MASK: rd_word[`ADC_IRQ_W-1:0] = irq_mask_q;
				default: rd_word = `ADC_RESET_WORD;
			endcase
		end
	end

	// one read in flight; address is refused while the answer waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= `ADC_RESET_WORD;
			rresp <= `ADC_RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= mapped(araddr) ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end else if (!rvalid) begin
				arready <= 1'b1;
			end
		end
	end

endmodule : adc_status_flags

`default_nettype wire

/* File: adc_status_flags_props.sv */
// Purpose: port timing checks for adc_status_flags
// Assumes: ce held high
// Notes: bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
`include "adc_flag_map.svh"

module adc_status_flags_props
	import adc_flag_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [`ADC_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire conv_evt_s conv,
	input wire logic [`ADC_NUM_CH-1:0] chan_enable,
	input wire logic irq
);
	// ****************
	// checks
	// ****************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic ar_hit = arvalid && arready;
	wire logic wr_hit = awvalid && awready && wvalid && wready;
	AST_RESET: assert property (disable iff (1'b0) !aresetn |=> chan_enable == '0 && !irq)
		else $error("reset left state");
	AST_RD_LAT: assert property (ar_hit |=> rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	AST_WR_LAT: assert property (wr_hit |-> ##2 bvalid)
		else $error("write answer off time");
	AST_UNMAPPED: assert property (ar_hit && (araddr == 8'h1c || araddr > 8'h3c)
		|=> rresp == 2'b10 && rdata == '0) else $error("unmapped read answered");
	AST_STAT_FMT: assert property (ar_hit && araddr == 8'h0c |=> rdata[31:18] == '0)
		else $error("status upper bits set");
	// enables move only at the edge that executes a held write
	AST_EN_QUIET: assert property ($changed(chan_enable) |-> !$past(awready))
		else $error("enable moved without write");
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(conv.done) || !$past(awready))
		else $error("irq rose without cause");
	AST_IRQ_FALL: assert property ($fell(irq) |-> !$past(awready))
		else $error("irq fell without write");
	cover property (ar_hit && conv.done);
	cover property (wr_hit);
	cover property ($rose(irq));
endmodule : adc_status_flags_props

bind adc_status_flags adc_status_flags_props u_props (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
	.rready, .rdata, .rresp, .conv, .chan_enable, .irq);
`default_nettype wire

/* File: adc_status_flags_tb.sv */
// Purpose: self-checking bench for adc_status_flags
// Assumes: wstrb held on, ce dropped only while the bus is idle
// Notes: coincident ends of conversion are timed off the bus take edge
`timescale 1ns/1ns
`default_nettype none

module adc_status_flags_tb;
	import adc_flag_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
	logic rvalid, irq;
	logic [7:0] awaddr = '0, araddr = '0, chan_enable;
	logic [31:0] wdata = '0, rdata, v;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, resp;
	conv_evt_s conv = '0;
	int n_errors = 0, compares = 0;
	adc_status_flags uut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .conv, .chan_enable, .irq);
	always #5 aclk = ~aclk;
	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cv(input chan_t c, input sample_t d);
		@(posedge aclk);
		conv <= '{1'b1, c, d};
		@(posedge aclk);
		conv <= '0;
	endtask : cv
	// an idle slave takes the address at the first edge, where the hit lands
	task automatic rd(input logic [7:0] a, input logic hit, input chan_t c);
		logic ok;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		conv <= '{hit, c, 10'h3c0};
		@(negedge aclk);
		ok = arready;
		@(posedge aclk);
		conv <= '0;
		while (!ok) begin
			@(negedge aclk);
			ok = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		v = rdata;
		resp = rresp;
		// ready held back a cycle so the answer must stand
		@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a, 1'b0, 3'h0);
		chk(v, exp);
	endtask : rc
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic hit, input chan_t c);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// each channel let go at the edge that takes it
		while (pa || pw) begin
			@(negedge aclk);
			pa = pa & ~awready;
			pw = pw & ~wready;
			@(posedge aclk);
			awvalid <= pa;
			wvalid <= pw;
		end
		// the write executes at the first edge after the later take
		conv <= '{hit, c, 10'h3c0};
		@(posedge aclk);
		conv <= '0;
		do @(negedge aclk); while (!bvalid);
		resp = bresp;
		@(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic fl();
		for (int i = 0; i < 8; i++)
			rd(8'h20 + 8'(4 * i), 1'b0, 3'h0);
		rd(8'h10, 1'b0, 3'h0);
		rd(8'h0c, 1'b0, 3'h0);
	endtask : fl
	task automatic end_of_test();
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic t_reset();
		chk(32'(chan_enable), 32'h0);
		chk(32'(irq), 32'h0);
		aresetn <= 1'b1;
		rc(8'h0c, 32'h0);
	endtask : t_reset
	task automatic t_basic();
		wr(8'h00, 32'h0f, 1'b0, 3'h0);
		chk(32'(resp), 32'h0);
		chk(32'(chan_enable), 32'h0f);
		cv(3'h1, 10'h123);
		rc(8'h0c, 32'h0001_0002);
		rc(8'h24, 32'h0000_0123);
		rc(8'h0c, 32'h0001_0000);
		rc(8'h10, 32'h0000_1123);
		rc(8'h0c, 32'h0);
		cv(3'h2, 10'h2aa);
		rc(8'h10, 32'h0000_22aa);
		rc(8'h0c, 32'h0);
		// a pulse while the clock enable is low must leave no trace
		@(posedge aclk);
		ce <= 1'b0;
		cv(3'h1, 10'h1ff);
		ce <= 1'b1;
		rc(8'h0c, 32'h0);
	endtask : t_basic
	task automatic t_general_overrun_flag();
		cv(3'h0, 10'h001);
		cv(3'h2, 10'h002);
		rc(8'h0c, 32'h0003_0005);
		rd(8'h0c, 1'b1, 3'h3);
		rc(8'h0c, 32'h0003_000d);
		cv(3'h1, 10'h004);
		rc(8'h10, 32'h0000_1004);
		rd(8'h0c, 1'b1, 3'h1);
		rc(8'h0c, 32'h0001_000f);
	endtask : t_general_overrun_flag
	task automatic t_chanread();
		fl();
		cv(3'h1, 10'h011);
		cv(3'h2, 10'h012);
		cv(3'h0, 10'h010);
		rd(8'h0c, 1'b0, 3'h0);
		rd(8'h28, 1'b1, 3'h1);
		rc(8'h0c, 32'h0003_0203);
	endtask : t_chanread
	task automatic t_disable();
		fl();
		cv(3'h1, 10'h021);
		wr(8'h04, 32'h08, 1'b1, 3'h1);
		chk(32'(chan_enable), 32'h07);
		rc(8'h08, 32'h07);
		rc(8'h0c, 32'h0003_0202);
		rc(8'h24, 32'h0000_03c0);
		rc(8'h10, 32'h0000_13c0);
	endtask : t_disable
	task automatic t_dropped();
		fl();
		cv(3'h0, 10'h030);
		rd(8'h10, 1'b1, 3'h3);
		rc(8'h0c, 32'h0);
		cv(3'h1, 10'h031);
		rd(8'h20, 1'b1, 3'h3);
		rc(8'h0c, 32'h0001_0002);
	endtask : t_dropped
	task automatic t_channel_overrun_flag();
		fl();
		cv(3'h2, 10'h040);
		cv(3'h2, 10'h041);
		rd(8'h28, 1'b0, 3'h0);
		rd(8'h0c, 1'b1, 3'h2);
		rc(8'h0c, 32'h0003_0004);
	endtask : t_channel_overrun_flag
	task automatic t_irq();
		rc(8'h14, 32'h0f);
		chk(32'(irq), 32'h0);
		wr(8'h18, 32'h08, 1'b0, 3'h0);
		chk(32'(irq), 32'h1);
		rc(8'h18, 32'h08);
		wr(8'h14, 32'h08, 1'b0, 3'h0);
		chk(32'(irq), 32'h0);
		rc(8'h14, 32'h07);
		cv(3'h3, 10'h050);
		@(negedge aclk);
		chk(32'(irq), 32'h1);
		wr(8'h14, 32'h0f, 1'b0, 3'h0);
		rc(8'h14, 32'h0);
		rc(8'h1c, 32'h0);
		chk(32'(resp), 32'h2);
		// an unmapped write is refused and changes nothing
		wr(8'h1c, 32'h0f, 1'b0, 3'h0);
		chk(32'(resp), 32'h2);
		rc(8'h14, 32'h0);
	endtask : t_irq
	initial begin
		repeat (20) @(posedge aclk);
		t_reset();
		t_basic();
		t_general_overrun_flag();
		t_chanread();
		t_disable();
		t_dropped();
		t_channel_overrun_flag();
		t_irq();
		end_of_test();
	end
	// the run needs a few hundred cycles; allow 30000, some eighty times that
	initial begin
		#300000;
		n_errors++;
		end_of_test();
	end
endmodule : adc_status_flags_tb
`default_nettype wire
